//--- core/apsel_pkg.sv
// Holds the register map, field layout and reset values of the pin mode and scan select block.
// Assumes a plain register port with 16-bit data and small word addresses.
package apsel_pkg;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam int unsigned ADDR_W = 4;                            // Width of the register address.
  localparam int unsigned DATA_W = 16;                           // Width of the register data.
  localparam int unsigned CH_N   = 16;                           // Bit positions per register.
  localparam logic [3:0] OFF_PIN_CONFIG  = 4'h0;                  // Pin configuration register.
  localparam logic [3:0] OFF_SCAN_SELECT = 4'h1;                  // Scan select register.
  localparam logic [3:0] OFF_PIN_STATE   = 4'h2;                  // Effective digital mode status.
  localparam logic [3:0] OFF_PORT_READ   = 4'h3;                  // Port read value status.

  // ****************************************************************
  // Field layout and reset values.
  // ****************************************************************
  localparam logic [15:0] PIN_CONFIG_RESET  = 16'h0000;           // All pins analog after reset.
  localparam logic [15:0] SCAN_SELECT_RESET = 16'h0000;           // No channel scanned after reset.
  localparam logic [15:0] IMPL_MASK         = 16'h9FFF;           // Bits 15 and 12:0 exist.
  localparam logic [15:0] LARGE_ONLY_MASK   = 16'h99C0;           // Bits 15, 12:11, 8:6.
  localparam logic [15:0] MID_MEM_MASK      = 16'h0600;           // Bits 10:9.
  localparam logic [15:0] PIN_COUNT_MASK    = 16'h0030;           // Bits 5:4.
  localparam logic [15:0] ZERO_WORD         = 16'h0000;           // All-zero word.

endpackage : apsel_pkg

//--- core/apsel_sync.sv
// Holds a two-flop synchroniser for a vector of pin levels.
// Assumes the inputs come from pads outside the clock domain.
`timescale 1ns/1ps
module apsel_sync #(
  parameter int unsigned W = 16
) (
  input  wire logic         i_clk,     // System clock.
  input  wire logic         i_srst,    // Synchronous reset, active high.
  input  wire logic [W-1:0] i_async,   // Raw pad levels.
  output logic      [W-1:0] o_sync     // Synchronised levels.
);

  logic [W-1:0] stage_one;             // First stage, read only by the second stage.

  // Two flip-flops per bit, the second feeding all logic.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stage_one <= '0;
      o_sync    <= '0;
    end else begin
      stage_one <= i_async;
      o_sync    <= stage_one;
    end
  end

endmodule : apsel_sync

//--- core/apsel_regs.sv
// Holds one 16-bit software register with a write mask.
// Assumes writes come as single-cycle strobes on the system clock.
`timescale 1ns/1ps
module apsel_regs (
  input  wire logic        i_clk,      // System clock.
  input  wire logic        i_srst,     // Synchronous reset, active high.
  input  wire logic        i_we,       // Write strobe for this register.
  input  wire logic [15:0] i_wdata,    // Write data.
  input  wire logic [15:0] i_mask,     // Writable bit positions.
  input  wire logic [15:0] i_reset,    // Reset value, a constant.
  output logic      [15:0] o_value     // Stored value, unwritable bits zero.
);

  logic [15:0] next_value;             // Value after a write.

  assign next_value = i_wdata & i_mask;

  // Store masked write data; bits outside the mask stay zero.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_value <= i_reset & i_mask;
    end else if (i_we) begin
      o_value <= next_value;
    end
  end

endmodule : apsel_regs

//--- core/apsel_top.sv
// Holds the pin mode and scan select logic of the converter.
// Assumes a register master that keeps the strobes one cycle long and never both at once.
// Assumes the disable and busy levels come from logic on the same clock.
// What this block does
// RL1 - Bit one: digital, port read, mux grounded.
// RL2 - Bit zero: analog, port read off, sampled.
// RL3 - Analog pins read back as zero.
// RL4 - Reset leaves every shared pin analog.
// RL5 - Converter disabled forces all pins digital.
// RL6 - Bits without pins stored but ignored.
// RL7 - Bit x controls channel x; 14:13 absent.
// RL8 - Scan bits select channels; sensor never scanned.
// RL9 - Variant-dependent bits are reserved when absent.
// RL10 - Unimplemented bits ignore writes, read zero.
// RL11 - Writes apply next cycle, conversion undisturbed.
`timescale 1ns/1ps
module apsel_top #(
  parameter logic [15:0] PIN_PRESENT = 16'h9FFF,  // Channels that have a pin.
  parameter logic        HAS_LARGE   = 1'b1,      // Largest variant bits exist.
  parameter logic        HAS_MID_MEM = 1'b1,      // Bits 10:9 exist.
  parameter logic        HAS_PIN_5_4 = 1'b1,      // Pin bits 5:4 exist.
  parameter logic [15:0] TEMP_CH     = 16'h0000   // One-hot sensor channel, zero if none.
) (
  input  wire logic        i_clk,             // System clock, 125 MHz.
  input  wire logic        i_srst,            // Synchronous reset, active high.
  input  wire logic [3:0]  i_addr,            // Register address.
  input  wire logic [15:0] i_wdata,           // Register write data.
  input  wire logic        i_wr,              // Write strobe.
  input  wire logic        i_rd,              // Read strobe.
  output logic      [15:0] o_rdata,           // Read data, one cycle after the strobe.
  input  wire logic        i_module_disable,  // Converter module disable, same domain.
  input  wire logic        i_conv_busy,       // Conversion in progress, same domain.
  input  wire logic [15:0] i_pin_level,       // Raw pad levels.
  output logic      [15:0] o_digital_mode,    // Pin in digital mode.
  output logic      [15:0] o_port_read_en,    // Port read input enabled.
  output logic      [15:0] o_port_read,       // Value seen by a port read.
  output logic      [15:0] o_mux_ground,      // Channel mux parked on analog ground.
  output logic      [15:0] o_scan_enable      // Channel joins the automatic scan.
);

  // ****************************************************************
  // Masks of the stored bits.
  // ****************************************************************
  // Positions 14:13 are never stored; variant bits drop out when absent. [RL7] [RL9] [RL10]
  wire [15:0] scan_mask;                      // Writable scan select bits.
  wire [15:0] pin_mask;                       // Writable pin configuration bits.
  assign scan_mask = apsel_pkg::IMPL_MASK
                   & ~(HAS_LARGE   ? apsel_pkg::ZERO_WORD : apsel_pkg::LARGE_ONLY_MASK)
                   & ~(HAS_MID_MEM ? apsel_pkg::ZERO_WORD : apsel_pkg::MID_MEM_MASK);
  assign pin_mask  = scan_mask
                   & ~(HAS_PIN_5_4 ? apsel_pkg::ZERO_WORD : apsel_pkg::PIN_COUNT_MASK);

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  wire        wr_pin;                         // Write to the pin configuration register.
  wire        wr_scan;                        // Write to the scan select register.
  assign wr_pin  = i_wr && (i_addr == apsel_pkg::OFF_PIN_CONFIG);
  assign wr_scan = i_wr && (i_addr == apsel_pkg::OFF_SCAN_SELECT);

  // ****************************************************************
  // Software registers.
  // ****************************************************************
  wire [15:0] pin_config;                     // Stored pin configuration.
  wire [15:0] scan_select;                    // Stored scan selection.

  // Reset value is all zero, so every shared pin starts analog. [RL4]
  apsel_regs u_pin_config (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_we    (wr_pin),
    .i_wdata (i_wdata),
    .i_mask  (pin_mask),
    .i_reset (apsel_pkg::PIN_CONFIG_RESET),
    .o_value (pin_config)
  );

  apsel_regs u_scan_select (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_we    (wr_scan),
    .i_wdata (i_wdata),
    .i_mask  (scan_mask),
    .i_reset (apsel_pkg::SCAN_SELECT_RESET),
    .o_value (scan_select)
  );

  // ****************************************************************
  // Pad synchroniser.
  // ****************************************************************
  wire [15:0] pin_sync;                       // Pad levels after two flops.
  apsel_sync #(.W(16)) u_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async (i_pin_level),
    .o_sync  (pin_sync)
  );

  // ****************************************************************
  // Pin mode decisions.
  // ****************************************************************
  wire [15:0] next_digital;                   // Effective digital mode.
  wire [15:0] next_scan;                      // Effective scan set.
  wire [15:0] next_read;                      // Port read value.
  // Disabled converter overrides every pinned bit to digital; pinless bits have no effect. [RL5] [RL6]
  assign next_digital = i_module_disable ? PIN_PRESENT : (pin_config & PIN_PRESENT); // [RL1] [RL2]
  // Sensor channel is removed from the scan set. [RL8]
  assign next_scan    = scan_select & scan_mask & ~TEMP_CH;
  // Analog pins read back as zero. [RL3]
  assign next_read    = pin_sync & next_digital;

  // The outputs follow the registers one cycle later; a running conversion only sees
  // the scan set and mux parking, and no state of it is touched here. [RL11]
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_digital_mode <= apsel_pkg::ZERO_WORD;
      o_port_read_en <= apsel_pkg::ZERO_WORD;
      o_port_read    <= apsel_pkg::ZERO_WORD;
      o_mux_ground   <= apsel_pkg::ZERO_WORD;
      o_scan_enable  <= apsel_pkg::ZERO_WORD;
    end else begin
      o_digital_mode <= next_digital;         // [RL1] [RL2]
      o_port_read_en <= next_digital;         // [RL1] [RL2]
      o_port_read    <= next_read;            // [RL3]
      o_mux_ground   <= next_digital;         // [RL1]
      o_scan_enable  <= next_scan;            // [RL8]
    end
  end

  // ****************************************************************
  // Read path.
  // ****************************************************************
  wire [15:0] read_mux;                       // Selected read word.
  assign read_mux = (i_addr == apsel_pkg::OFF_PIN_CONFIG)  ? pin_config     :
                    (i_addr == apsel_pkg::OFF_SCAN_SELECT) ? scan_select    :
                    (i_addr == apsel_pkg::OFF_PIN_STATE)   ? o_digital_mode :
                    (i_addr == apsel_pkg::OFF_PORT_READ)   ? o_port_read    :
                    apsel_pkg::ZERO_WORD;

  // Read data stand only in the cycle after the strobe; otherwise zero.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= apsel_pkg::ZERO_WORD;
    end else begin
      o_rdata <= i_rd ? read_mux : apsel_pkg::ZERO_WORD;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  AST_DIGITAL_FOLLOWS: assert property (@(posedge i_clk) disable iff (i_srst) // [RL1]
    (!i_module_disable) |=> (o_digital_mode == ($past(pin_config) & PIN_PRESENT)))
    else $error("Digital mode does not follow the pin configuration.");

  AST_ANALOG_READ_ZERO: assert property (@(posedge i_clk) disable iff (i_srst) // [RL3]
    (o_port_read & ~o_digital_mode) == 16'h0000)
    else $error("An analog pin reads back nonzero.");

  AST_ANALOG_OFF: assert property (@(posedge i_clk) disable iff (i_srst) // [RL2]
    (o_port_read_en == o_digital_mode) && (o_mux_ground == o_digital_mode))
    else $error("Read enable or mux ground disagrees with the mode.");

  AST_RESET_ANALOG: assert property (@(posedge i_clk) // [RL4]
    ($past(i_srst) && !i_srst) |-> (pin_config == 16'h0000) && (o_digital_mode == 16'h0000))
    else $error("Pins are not analog after reset.");

  AST_DISABLE_DIGITAL: assert property (@(posedge i_clk) disable iff (i_srst) // [RL5]
    i_module_disable |=> (o_digital_mode == PIN_PRESENT))
    else $error("Disabled converter did not force digital mode.");

  AST_PINLESS_IGNORED: assert property (@(posedge i_clk) disable iff (i_srst) // [RL6]
    (o_digital_mode & ~PIN_PRESENT) == 16'h0000)
    else $error("A bit without a pin had an effect.");

  AST_GAP_ZERO: assert property (@(posedge i_clk) disable iff (i_srst) // [RL7]
    (pin_config[14:13] == 2'h0) && (scan_select[14:13] == 2'h0))
    else $error("Unimplemented bits 14:13 are nonzero.");

  AST_SENSOR_SKIP: assert property (@(posedge i_clk) disable iff (i_srst) // [RL8]
    (o_scan_enable & TEMP_CH) == 16'h0000)
    else $error("The sensor channel joined the scan.");

  AST_RESERVED_ZERO: assert property (@(posedge i_clk) disable iff (i_srst) // [RL9]
    ((pin_config & ~pin_mask) == 16'h0000) && ((scan_select & ~scan_mask) == 16'h0000))
    else $error("A reserved bit holds a one.");

  AST_WRITE_MASKED: assert property (@(posedge i_clk) disable iff (i_srst) // [RL10]
    wr_scan |=> (scan_select == ($past(i_wdata) & scan_mask)))
    else $error("Scan select write not stored as masked.");

  AST_WRITE_NEXT: assert property (@(posedge i_clk) disable iff (i_srst) // [RL11]
    wr_scan ##1 !i_srst |=> (o_scan_enable == ($past(i_wdata, 2) & scan_mask & ~TEMP_CH)))
    else $error("Scan write did not reach the output two edges later.");

  // ****************************************************************
  // Read path checks.
  // ****************************************************************
  // A configuration read returns the stored word, pinless bits included.
  AST_READ_CONFIG: assert property (@(posedge i_clk) disable iff (i_srst) // [RL6]
    (i_rd && (i_addr == apsel_pkg::OFF_PIN_CONFIG)) |=>
      (o_rdata == $past(pin_config)))
    else $error("Pin configuration read is wrong.");

  // A scan select read returns the stored word.
  AST_READ_SCAN: assert property (@(posedge i_clk) disable iff (i_srst) // [RL8]
    (i_rd && (i_addr == apsel_pkg::OFF_SCAN_SELECT)) |=>
      (o_rdata == $past(scan_select)))
    else $error("Scan select read is wrong.");

  // A port read shows zero on every pin that was analog.
  AST_READ_PORT: assert property (@(posedge i_clk) disable iff (i_srst) // [RL3]
    (i_rd && (i_addr == apsel_pkg::OFF_PORT_READ)) |=>
      ((o_rdata & ~$past(o_digital_mode)) == 16'h0000))
    else $error("Port read shows a one on an analog pin.");

  // Addresses past the status words hold nothing and read zero.
  AST_READ_UNMAPPED: assert property (@(posedge i_clk) disable iff (i_srst) // [RL10]
    (i_rd && (i_addr > apsel_pkg::OFF_PORT_READ)) |=>
      (o_rdata == 16'h0000))
    else $error("An empty address reads nonzero.");

  // Between reads the data lines rest at zero.
  AST_READ_IDLE: assert property (@(posedge i_clk) disable iff (i_srst) // [RL10]
    (!i_rd) |=>
      (o_rdata == 16'h0000))
    else $error("Read data stood outside the read cycle.");

  // ****************************************************************
  // Mode and variant checks.
  // ****************************************************************
  // The mux parks on ground exactly where the stored bit asks for digital.
  AST_MUX_FOLLOWS: assert property (@(posedge i_clk) disable iff (i_srst) // [RL1]
    (!i_module_disable) |=>
      (o_mux_ground == ($past(pin_config) & PIN_PRESENT)))
    else $error("Mux parking does not follow the configuration.");

  // An analog pin has its read input off and its mux free to sample.
  AST_ANALOG_SAMPLE: assert property (@(posedge i_clk) disable iff (i_srst) // [RL2]
    (!i_module_disable) |=>
      (((o_port_read_en | o_mux_ground) & ~$past(pin_config)) == 16'h0000))
    else $error("An analog pin is not left to the converter.");

  // A digital pin passes the synchronised pad level to the port read.
  AST_PORT_READ_LIVE: assert property (@(posedge i_clk) disable iff (i_srst) // [RL1]
    1'b1 |=>
      (o_port_read == ($past(pin_sync) & o_digital_mode)))
    else $error("A digital pin does not show its pad level.");

  // Reset clears the scan set along with the pin modes.
  AST_RESET_SCAN: assert property (@(posedge i_clk) // [RL4]
    ($past(i_srst) && !i_srst) |->
      ((scan_select == 16'h0000) && (o_scan_enable == 16'h0000)))
    else $error("The scan set is not clear after reset.");

  // A switched-off converter leaves read inputs on and the mux parked on every pinned channel.
  AST_DISABLE_ALL: assert property (@(posedge i_clk) disable iff (i_srst) // [RL5]
    i_module_disable |=>
      ((o_port_read_en == PIN_PRESENT) && (o_mux_ground == PIN_PRESENT)))
    else $error("Disabled converter left a pin analog.");

  // Switching the converter off keeps the stored configuration for later.
  AST_DISABLE_KEEPS: assert property (@(posedge i_clk) disable iff (i_srst) // [RL5]
    (i_module_disable && !wr_pin) |=>
      $stable(pin_config))
    else $error("Disabling the converter changed the configuration.");

  // A pinless bit is still stored as written.
  AST_PIN_STORE: assert property (@(posedge i_clk) disable iff (i_srst) // [RL6]
    wr_pin |=>
      (pin_config == ($past(i_wdata) & pin_mask)))
    else $error("Pin configuration write not stored as masked.");

  // The scan set never holds a channel that software left out.
  AST_SCAN_SUBSET: assert property (@(posedge i_clk) disable iff (i_srst) // [RL8]
    1'b1 |=>
      ((o_scan_enable & ~$past(scan_select)) == 16'h0000))
    else $error("An unselected channel joined the scan.");

  // Without the largest variant, its bits stay zero in both registers.
  AST_VARIANT_LARGE: assert property (@(posedge i_clk) disable iff (i_srst) // [RL9]
    (!HAS_LARGE) |->
      (((pin_config | scan_select) & apsel_pkg::LARGE_ONLY_MASK) == 16'h0000))
    else $error("A largest-variant bit is stored.");

  // Without the mid-memory bits, positions 10:9 stay zero.
  AST_VARIANT_MID: assert property (@(posedge i_clk) disable iff (i_srst) // [RL9]
    (!HAS_MID_MEM) |->
      (((pin_config | scan_select) & apsel_pkg::MID_MEM_MASK) == 16'h0000))
    else $error("A mid-memory bit is stored.");

  // Without pins 5:4, those configuration bits stay zero.
  AST_VARIANT_PINS: assert property (@(posedge i_clk) disable iff (i_srst) // [RL9]
    (!HAS_PIN_5_4) |->
      ((pin_config & apsel_pkg::PIN_COUNT_MASK) == 16'h0000))
    else $error("A pin bit 5:4 is stored.");

  // ****************************************************************
  // Write timing checks.
  // ****************************************************************
  // A configuration write reaches the mode outputs two edges later.
  AST_MODE_NEXT: assert property (@(posedge i_clk) disable iff (i_srst) // [RL11]
    (wr_pin ##1 !i_module_disable) |=>
      (o_digital_mode == ($past(i_wdata, 2) & pin_mask & PIN_PRESENT)))
    else $error("Configuration write did not reach the mode.");

  // A write lands while a conversion runs; nothing waits on the converter.
  AST_BUSY_WRITE: assert property (@(posedge i_clk) disable iff (i_srst) // [RL11]
    (wr_pin && i_conv_busy) |=>
      (pin_config == ($past(i_wdata) & pin_mask)))
    else $error("A write during conversion was lost.");

  // Writes to the status words or empty places leave both registers alone.
  AST_STATUS_WRITE: assert property (@(posedge i_clk) disable iff (i_srst) // [RL10]
    (i_wr && !wr_pin && !wr_scan) |=>
      ($stable(pin_config) && $stable(scan_select)))
    else $error("A write to a read-only place changed a register.");

endmodule : apsel_top

//--- testbench/tb.sv
// Holds the self-checking testbench of the pin mode and scan select block.
// Assumes the design files of core/ are compiled first; no partner model is used.
`timescale 1ns/1ps
module tb;

  // ****************************************************************
  // Stimulus and observation signals.
  // ****************************************************************
  logic        i_clk            = 1'b0;     // System clock, 8 ns period.
  logic        i_srst           = 1'b1;     // Synchronous reset, active high.
  logic [3:0]  i_addr           = 4'h0;     // Register address.
  logic [15:0] i_wdata          = 16'h0000; // Register write data.
  logic        i_wr             = 1'b0;     // Write strobe.
  logic        i_rd             = 1'b0;     // Read strobe.
  logic        i_module_disable = 1'b0;     // Converter switched off when high.
  logic        i_conv_busy      = 1'b0;     // Conversion running.
  logic [15:0] i_pin_level      = 16'h0000; // Pad levels.
  logic [15:0] o_rdata;                     // Read data.
  logic [15:0] o_digital_mode;              // Digital mode per pin.
  logic [15:0] o_port_read_en;              // Port read enable per pin.
  logic [15:0] o_port_read;                 // Port read value per pin.
  logic [15:0] o_mux_ground;                // Mux parked on ground per channel.
  logic [15:0] o_scan_enable;               // Scan membership per channel.
  logic [15:0] small_rdata;                 // Read data of the smallest variant.
  logic [15:0] small_digital;               // Digital mode of the smallest variant.
  int          miscompares      = 0;        // Mismatches seen.
  int          check_count      = 0;        // Comparisons made.
  // Bit 15 has no pin here and channel 0 stands in for the sensor, so both exclusions show.
  localparam logic [15:0] PRESENT = 16'h1FFF; // Channels with a pin.
  localparam logic [15:0] SENSOR  = 16'h0001; // Sensor channel, never scanned.

  // The clock toggles every half period.
  always #4 i_clk = ~i_clk;

  apsel_top #(.PIN_PRESENT(PRESENT), .TEMP_CH(SENSOR)) dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_module_disable(i_module_disable),
    .i_conv_busy(i_conv_busy), .i_pin_level(i_pin_level), .o_digital_mode(o_digital_mode),
    .o_port_read_en(o_port_read_en), .o_port_read(o_port_read), .o_mux_ground(o_mux_ground),
    .o_scan_enable(o_scan_enable));

  // Smallest variant: every variant bit absent, so only the masks differ.
  apsel_top #(.PIN_PRESENT(PRESENT), .HAS_LARGE(1'b0), .HAS_MID_MEM(1'b0),
              .HAS_PIN_5_4(1'b0), .TEMP_CH(SENSOR)) dut_small (
    .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(small_rdata), .i_module_disable(i_module_disable),
    .i_conv_busy(i_conv_busy), .i_pin_level(i_pin_level), .o_digital_mode(small_digital),
    .o_port_read_en(), .o_port_read(), .o_mux_ground(), .o_scan_enable());

  // ****************************************************************
  // Bus tasks, compare task and the closing report.
  // ****************************************************************
  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // Compares one 16-bit result with case equality so unknowns never match.
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_word

  // One-cycle write strobe beside address and data.
  task automatic bus_write(input logic [3:0] addr, input logic [15:0] data);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= addr;
    i_wdata <= data;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : bus_write

  // One-cycle read strobe; the data is taken in the following cycle only.
  task automatic bus_read(input logic [3:0] addr, output logic [15:0] data);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= addr;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 data = o_rdata;
  endtask : bus_read

  // Lets the output flops take up a change that landed at the previous edge.
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : settle

  // Checks the three mode outputs against one expected digital set.
  task automatic check_mode(input logic [15:0] exp);
    check_word(o_digital_mode, exp, "digital mode");
    check_word(o_port_read_en, exp, "port read enable");
    check_word(o_mux_ground, exp, "mux ground");
  endtask : check_mode

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  // Reset leaves both registers clear and every pin analog.
  task automatic scn_reset();
    logic [15:0] d;
    bus_read(apsel_pkg::OFF_PIN_CONFIG, d);
    check_word(d, apsel_pkg::PIN_CONFIG_RESET, "pin config reset");
    bus_read(apsel_pkg::OFF_SCAN_SELECT, d);
    check_word(d, apsel_pkg::SCAN_SELECT_RESET, "scan select reset");
    check_mode(16'h0000);
    check_word(o_scan_enable, 16'h0000, "scan reset");
  endtask : scn_reset

  // All ones while a conversion runs: absent bits drop, pinless bits stay stored but idle.
  task automatic scn_config();
    logic [15:0] d;
    @(posedge i_clk);
    i_conv_busy <= 1'b1;
    bus_write(apsel_pkg::OFF_PIN_CONFIG, 16'hFFFF);
    settle(1);
    check_mode(PRESENT);
    check_word(small_digital, 16'h000F, "small variant mode");
    bus_read(apsel_pkg::OFF_PIN_CONFIG, d);
    check_word(d, 16'h9FFF, "pin config readback");
    check_word(small_rdata, 16'h000F, "small pin readback");
    bus_write(apsel_pkg::OFF_PIN_CONFIG, 16'h00F0);
    settle(1);
    check_mode(16'h00F0);
    @(posedge i_clk);
    i_conv_busy <= 1'b0;
  endtask : scn_config

  // Analog pins read zero whatever the pad level; digital pins follow the pad.
  task automatic scn_port_read();
    logic [15:0] d;
    @(posedge i_clk);
    i_pin_level <= 16'hFFFF;
    settle(4);
    check_word(o_port_read, 16'h00F0, "port read mixed");
    bus_read(apsel_pkg::OFF_PIN_STATE, d);
    check_word(d, 16'h00F0, "mode status read");
    bus_read(apsel_pkg::OFF_PORT_READ, d);
    check_word(d, 16'h00F0, "port read status");
    bus_write(apsel_pkg::OFF_PIN_CONFIG, 16'h0000);
    settle(1);
    check_word(o_port_read, 16'h0000, "port read analog");
  endtask : scn_port_read

  // Scan bits pick channels; absent bits and the sensor never join.
  task automatic scn_scan();
    logic [15:0] d;
    bus_write(apsel_pkg::OFF_SCAN_SELECT, 16'hFFFF);
    bus_read(apsel_pkg::OFF_SCAN_SELECT, d);
    check_word(d, 16'h9FFF, "scan readback");
    check_word(small_rdata, 16'h003F, "small scan readback");
    settle(1);
    check_word(o_rdata, apsel_pkg::ZERO_WORD, "read data idle");
    check_word(o_scan_enable, 16'h9FFE, "scan set");
    bus_write(apsel_pkg::OFF_SCAN_SELECT, 16'h0005);
    settle(1);
    check_word(o_scan_enable, 16'h0004, "scan subset");
  endtask : scn_scan

  // Switching the converter off forces every pinned channel digital.
  task automatic scn_disable();
    @(posedge i_clk);
    i_module_disable <= 1'b1;
    settle(2);
    check_mode(PRESENT);
    check_word(o_port_read, PRESENT, "port read disabled");
    @(posedge i_clk);
    i_module_disable <= 1'b0;
    settle(2);
    check_mode(16'h0000);
  endtask : scn_disable

  // Unmapped places read zero and a write to status leaves the mode alone.
  task automatic scn_unmapped();
    logic [15:0] d;
    bus_write(4'hF, 16'hFFFF);
    bus_write(apsel_pkg::OFF_PIN_STATE, 16'hFFFF);
    settle(1);
    check_mode(16'h0000);
    bus_read(4'hF, d);
    check_word(d, 16'h0000, "unmapped read");
  endtask : scn_unmapped

  // A reset in mid-run clears both registers and returns every pin to analog.
  task automatic scn_mid_reset();
    logic [15:0] d;
    bus_write(apsel_pkg::OFF_PIN_CONFIG, 16'h00F0);
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    bus_read(apsel_pkg::OFF_PIN_CONFIG, d);
    check_word(d, apsel_pkg::PIN_CONFIG_RESET, "pin config after reset");
    check_mode(16'h0000);
    check_word(o_scan_enable, apsel_pkg::SCAN_SELECT_RESET, "scan after reset");
  endtask : scn_mid_reset

  // ****************************************************************
  // Main sequence and hang guard.
  // ****************************************************************
  initial begin
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    scn_reset();
    scn_config();
    scn_port_read();
    scn_scan();
    scn_disable();
    scn_unmapped();
    scn_mid_reset();
    complete_run();
  end

  // Cuts the run short if the sequence overruns its cycle budget.
  initial begin
    repeat (5000) @(posedge i_clk);
    miscompares++;
    complete_run();
  end

endmodule : tb
